/* brownout_pkg.sv */
package brownout_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] CONFIG_OFFSET = 4'h0;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
	localparam logic [ADDR_W-1:0] EVENT_OFFSET = 4'h8;
	localparam logic [ADDR_W-1:0] CAUSE_OFFSET = 4'hc;
	localparam int CFG_SEL_LSB = 0;
	localparam int CFG_RST_EN_BIT = 3;
	localparam int CFG_MON_EN_BIT = 4;
	localparam int CFG_EXIT_IRQ_BIT = 5;
	localparam int CFG_ENTRY_IRQ_BIT = 6;
	localparam int EXIT_EVENT_BIT = 24;
	localparam int ENTRY_EVENT_BIT = 25;
	localparam logic [31:0] BROWNOUT_EXIT_EVENT_MASK = 32'h0100_0000;
	localparam logic [31:0] BROWNOUT_ENTRY_EVENT_MASK = 32'h0200_0000;
	localparam logic [2:0] THRESHOLD_DEFAULT = 3'h1;
	localparam logic RESET_ENABLE_DEFAULT = 1'b1;
	localparam logic MONITOR_ENABLE_DEFAULT = 1'b1;
	localparam int CLOCK_HZ = 20000000;
	localparam int SETTLE_NS = 3300;
	localparam int SETTLE_CYCLES = (SETTLE_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
	localparam int SETTLE_W = 7;
endpackage

/* level_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module level_sync (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic async_in,
	output logic sync_out
);
	logic stage_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			stage_q <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage_q <= async_in;
			sync_out <= stage_q;
		end
	end
endmodule // level_sync
`default_nettype wire

/* brownout_supervisor_control.sv */
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Three-bit threshold code, default code one.
// - New threshold settles within 3.3 us.
// - Brownout bit sets on downward crossing.
// - Brownout bit clears on upward crossing.
// - Reset enable issues reset on entry.
// - Monitor enable gates detection and events.
// - Exit interrupt on brownout bit fall.
// - Entry interrupt on brownout bit rise.
// - Reset restores defaults; wake restores threshold and reset enable only.
// - Reset-on-brownout active out of reset.
// - Live status readable as brownout bit.
// - Reset cause flag marks brownout reset.
// - Separate entry/exit events clear on read.
// - Polling works without interrupts or reset.
// - Interrupts use shared system controller line.
// - Exit event at bit 24.
// - Entry event at bit 25.
// - Writing one clears event bits.
module brownout_supervisor_control (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic por_nrst_in,
	input wire logic wake_in,
	input wire logic comparator_in,
	input wire logic [brownout_pkg::ADDR_W-1:0] addr_in,
	input wire logic [brownout_pkg::DATA_W-1:0] wdata_in,
	input wire logic write_in,
	input wire logic read_in,
	output logic [brownout_pkg::DATA_W-1:0] rdata_out,
	output logic [2:0] threshold_out,
	output logic monitor_enable_out,
	output logic brownout_reset_out,
	output logic sysctrl_irq_out
);
	import brownout_pkg::*;

	logic [2:0] brownout_threshold_select_q;
	logic brownout_reset_enable_q;
	logic supply_monitor_enable_q;
	logic brownout_exit_irq_enable_q;
	logic brownout_entry_irq_enable_q;
	logic [SETTLE_W-1:0] settle_q;
	logic comp_sync;
	logic brownout_q;
	logic entry_event_q;
	logic exit_event_q;
	logic cause_q;
	logic brownout_armed_q;
	logic chip_reset_low;
	logic reset_seen;
	logic reset_seen_q;
	logic reset_req_d;
	logic reset_req_q;
	logic [2:0] wdata_sel;
	logic rise;
	logic fall;
	logic cfg_wr;
	logic event_rd;
	logic event_wr;

	assign cfg_wr = write_in && addr_in == CONFIG_OFFSET;
	assign event_rd = read_in && addr_in == EVENT_OFFSET;
	assign event_wr = write_in && addr_in == EVENT_OFFSET;
	assign chip_reset_low = !nrst_in;
	assign wdata_sel = wdata_in[CFG_SEL_LSB +: 3];

	level_sync u_comp_sync (
		.clock_in(clock_in),
		.nrst_in(nrst_in),
		.async_in(comparator_in),
		.sync_out(comp_sync)
	);

	// The chip reset is watched from the power-on domain, so it is synchronised like a pin.
	level_sync u_reset_sync (
		.clock_in(clock_in),
		.nrst_in(por_nrst_in),
		.async_in(chip_reset_low),
		.sync_out(reset_seen)
	);

	// Configuration; wake restores the threshold and reset enable defaults, not the other fields.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			brownout_threshold_select_q <= THRESHOLD_DEFAULT;
			brownout_reset_enable_q <= RESET_ENABLE_DEFAULT;
			supply_monitor_enable_q <= MONITOR_ENABLE_DEFAULT;
			brownout_exit_irq_enable_q <= 1'b0;
			brownout_entry_irq_enable_q <= 1'b0;
		end else if (wake_in) begin
			brownout_threshold_select_q <= THRESHOLD_DEFAULT;
			brownout_reset_enable_q <= RESET_ENABLE_DEFAULT;
		end else if (cfg_wr) begin
			brownout_threshold_select_q <= wdata_in[CFG_SEL_LSB +: 3];
			brownout_reset_enable_q <= wdata_in[CFG_RST_EN_BIT];
			supply_monitor_enable_q <= wdata_in[CFG_MON_EN_BIT];
			brownout_exit_irq_enable_q <= wdata_in[CFG_EXIT_IRQ_BIT];
			brownout_entry_irq_enable_q <= wdata_in[CFG_ENTRY_IRQ_BIT];
		end
	end

	// Comparisons are ignored while the analogue level settles after a change.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			settle_q <= '0;
		end else if (cfg_wr || wake_in) begin
			settle_q <= SETTLE_W'(SETTLE_CYCLES);
		end else if (settle_q != '0) begin
			settle_q <= settle_q - 1'b1;
		end
	end

	// Brownout bit follows the comparator only while monitoring.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			brownout_q <= 1'b0;
		end else if (!supply_monitor_enable_q) begin
			brownout_q <= 1'b0;
		end else if (settle_q == '0) begin
			brownout_q <= comp_sync;
		end
	end

	assign rise = supply_monitor_enable_q && settle_q == '0 && comp_sync && !brownout_q;
	assign fall = supply_monitor_enable_q && settle_q == '0 && !comp_sync && brownout_q;

	// Events latch regardless of interrupt and reset enables; a new edge wins over clear.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			entry_event_q <= 1'b0;
			exit_event_q <= 1'b0;
		end else begin
			if (rise) begin
				entry_event_q <= 1'b1;
			end else if (event_rd || (event_wr && wdata_in[ENTRY_EVENT_BIT])) begin
				entry_event_q <= 1'b0;
			end
			if (fall) begin
				exit_event_q <= 1'b1;
			end else if (event_rd || (event_wr && wdata_in[EXIT_EVENT_BIT])) begin
				exit_event_q <= 1'b0;
			end
		end
	end

	assign reset_req_d = rise && brownout_reset_enable_q;

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			reset_req_q <= 1'b0;
		end else begin
			reset_req_q <= reset_req_d;
		end
	end

	// Cause flag lives on the power-on reset so the brownout reset cannot wipe it.
	always_ff @(posedge clock_in or negedge por_nrst_in) begin
		if (!por_nrst_in) begin
			cause_q <= 1'b0;
		end else if (reset_req_d) begin
			cause_q <= 1'b1;
		end else if (reset_seen && !brownout_armed_q) begin
			cause_q <= 1'b0;
		end
	end

	// The first chip reset after a request is taken as the one that it caused.
	// A request that the system never acts on makes the next reset look like a brownout.
	always_ff @(posedge clock_in or negedge por_nrst_in) begin
		if (!por_nrst_in) begin
			brownout_armed_q <= 1'b0;
		end else if (reset_req_d) begin
			brownout_armed_q <= 1'b1;
		end else if (reset_seen_q && !reset_seen) begin
			brownout_armed_q <= 1'b0;
		end
	end

	always_ff @(posedge clock_in or negedge por_nrst_in) begin
		if (!por_nrst_in) begin
			reset_seen_q <= 1'b0;
		end else begin
			reset_seen_q <= reset_seen;
		end
	end

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_out <= '0;
		end else if (read_in) begin
			case (addr_in)
				CONFIG_OFFSET: rdata_out <= {25'h0, brownout_entry_irq_enable_q,
					brownout_exit_irq_enable_q, supply_monitor_enable_q,
					brownout_reset_enable_q, brownout_threshold_select_q};
				STATUS_OFFSET: rdata_out <= {31'h0, brownout_q};
				EVENT_OFFSET: rdata_out <= (entry_event_q ? BROWNOUT_ENTRY_EVENT_MASK : 32'h0)
					| (exit_event_q ? BROWNOUT_EXIT_EVENT_MASK : 32'h0);
				CAUSE_OFFSET: rdata_out <= {31'h0, cause_q};
				default: rdata_out <= '0;
			endcase
		end else begin
			rdata_out <= '0;
		end
	end

	assign threshold_out = brownout_threshold_select_q;
	assign monitor_enable_out = supply_monitor_enable_q;
	assign brownout_reset_out = reset_req_q;
	assign sysctrl_irq_out = (entry_event_q && brownout_entry_irq_enable_q)
		|| (exit_event_q && brownout_exit_irq_enable_q);

	property p_reset_on_entry;
		@(posedge clock_in) disable iff (!nrst_in)
		(rise && brownout_reset_enable_q) |=> brownout_reset_out;
	endproperty
	a_reset_on_entry: assert property (p_reset_on_entry) else $error("no reset on entry");

	property p_no_reset_disabled;
		@(posedge clock_in) disable iff (!nrst_in)
		!brownout_reset_enable_q && !$past(brownout_reset_enable_q) |-> !brownout_reset_out;
	endproperty
	a_no_reset_disabled: assert property (p_no_reset_disabled) else $error("reset while off");

	property p_entry_latch;
		@(posedge clock_in) disable iff (!nrst_in)
		rise |=> entry_event_q && brownout_q;
	endproperty
	a_entry_latch: assert property (p_entry_latch) else $error("entry not latched");

	property p_exit_latch;
		@(posedge clock_in) disable iff (!nrst_in)
		fall |=> exit_event_q && !brownout_q;
	endproperty
	a_exit_latch: assert property (p_exit_latch) else $error("exit not latched");

	property p_read_clears;
		@(posedge clock_in) disable iff (!nrst_in)
		event_rd && !rise && !fall |=> !entry_event_q && !exit_event_q;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("read did not clear");

	property p_monitor_off;
		@(posedge clock_in) disable iff (!nrst_in)
		!supply_monitor_enable_q |=> !brownout_q;
	endproperty
	a_monitor_off: assert property (p_monitor_off) else $error("bit set while off");

	property p_settle;
		@(posedge clock_in) disable iff (!nrst_in)
		cfg_wr || wake_in |=> settle_q == SETTLE_W'(SETTLE_CYCLES);
	endproperty
	a_settle: assert property (p_settle) else $error("settle window wrong");

	property p_settle_count;
		@(posedge clock_in) disable iff (!nrst_in)
		settle_q != '0 && !cfg_wr && !wake_in |=> settle_q == $past(settle_q) - 1'b1;
	endproperty
	a_settle_count: assert property (p_settle_count) else $error("settle count wrong");

	property p_settle_hold;
		@(posedge clock_in) disable iff (!nrst_in)
		supply_monitor_enable_q && settle_q != '0 |=> brownout_q == $past(brownout_q);
	endproperty
	a_settle_hold: assert property (p_settle_hold) else $error("bit moved while settling");

	property p_wake_defaults;
		@(posedge clock_in) disable iff (!nrst_in)
		wake_in |=> brownout_reset_enable_q && threshold_out == THRESHOLD_DEFAULT;
	endproperty
	a_wake_defaults: assert property (p_wake_defaults) else $error("wake defaults");

	property p_irq_entry;
		@(posedge clock_in) disable iff (!nrst_in)
		entry_event_q && brownout_entry_irq_enable_q |-> sysctrl_irq_out;
	endproperty
	a_irq_entry: assert property (p_irq_entry) else $error("irq missing");

	property p_irq_exit;
		@(posedge clock_in) disable iff (!nrst_in)
		exit_event_q && brownout_exit_irq_enable_q |-> sysctrl_irq_out;
	endproperty
	a_irq_exit: assert property (p_irq_exit) else $error("exit irq missing");

	property p_irq_quiet;
		@(posedge clock_in) disable iff (!nrst_in)
		!brownout_entry_irq_enable_q && !brownout_exit_irq_enable_q |-> !sysctrl_irq_out;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq while disabled");

	property p_reset_pulse;
		@(posedge clock_in) disable iff (!nrst_in)
		brownout_reset_out |=> !brownout_reset_out;
	endproperty
	a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse too long");

	property p_no_reset_monitor_off;
		@(posedge clock_in) disable iff (!nrst_in)
		!supply_monitor_enable_q |=> !brownout_reset_out;
	endproperty
	a_no_reset_monitor_off: assert property (p_no_reset_monitor_off) else $error("reset while off");

	property p_status_read;
		@(posedge clock_in) disable iff (!nrst_in)
		read_in && addr_in == STATUS_OFFSET |=> rdata_out == {31'h0, $past(brownout_q)};
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read wrong");

	property p_event_read;
		@(posedge clock_in) disable iff (!nrst_in)
		event_rd |=> rdata_out[EXIT_EVENT_BIT] == $past(exit_event_q)
			&& rdata_out[ENTRY_EVENT_BIT] == $past(entry_event_q);
	endproperty
	a_event_read: assert property (p_event_read) else $error("event read wrong");

	property p_write_clear;
		@(posedge clock_in) disable iff (!nrst_in)
		event_wr && wdata_in[EXIT_EVENT_BIT] && !fall |=> !exit_event_q;
	endproperty
	a_write_clear: assert property (p_write_clear) else $error("write one kept event");

	property p_write_zero_keeps;
		@(posedge clock_in) disable iff (!nrst_in)
		event_wr && !wdata_in[ENTRY_EVENT_BIT] && entry_event_q |=> entry_event_q;
	endproperty
	a_write_zero_keeps: assert property (p_write_zero_keeps) else $error("write zero cleared");

	property p_threshold_write;
		@(posedge clock_in) disable iff (!nrst_in)
		cfg_wr && !wake_in |=> threshold_out == $past(wdata_sel);
	endproperty
	a_threshold_write: assert property (p_threshold_write) else $error("threshold not taken");

	property p_cause_set;
		@(posedge clock_in) disable iff (!por_nrst_in)
		reset_req_d |=> cause_q;
	endproperty
	a_cause_set: assert property (p_cause_set) else $error("cause not recorded");

	property p_cause_survives;
		@(posedge clock_in) disable iff (!por_nrst_in)
		cause_q && brownout_armed_q |=> cause_q;
	endproperty
	a_cause_survives: assert property (p_cause_survives) else $error("cause lost");

	property p_cause_foreign;
		@(posedge clock_in) disable iff (!por_nrst_in)
		reset_seen && !brownout_armed_q && !reset_req_d |=> !cause_q;
	endproperty
	a_cause_foreign: assert property (p_cause_foreign) else $error("cause kept");

	c_entry: cover property (@(posedge clock_in) disable iff (!nrst_in) rise);
	c_exit: cover property (@(posedge clock_in) disable iff (!nrst_in) fall);
	c_reset: cover property (@(posedge clock_in) disable iff (!nrst_in) brownout_reset_out);
	c_both: cover property (@(posedge clock_in) disable iff (!nrst_in) entry_event_q && exit_event_q);
	c_cause: cover property (@(posedge clock_in) disable iff (!por_nrst_in) cause_q && reset_seen);
endmodule // brownout_supervisor_control
`default_nettype wire

/* tb_brownout_supervisor_control.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_brownout_supervisor_control;
import brownout_pkg::*;
logic clock_in = 1'h0;
logic nrst_in = 1'h0;
logic por_nrst_in = 1'h0;
logic wake_in = 1'h0;
logic comparator_in = 1'h0;
logic write_in = 1'h0;
logic read_in = 1'h0;
logic [ADDR_W-1:0] addr_in = 4'h0;
logic [DATA_W-1:0] wdata_in = 32'h0;
logic [DATA_W-1:0] rdata_out;
logic [DATA_W-1:0] d;
logic [2:0] threshold_out;
logic monitor_enable_out;
logic brownout_reset_out;
logic sysctrl_irq_out;
logic [31:0] rnd = 32'hdd46;
int errors = 0;
int checks = 0;
int pulses = 0;
always #25 clock_in = ~clock_in;
brownout_supervisor_control DUT (.clock_in(clock_in), .nrst_in(nrst_in),
	.por_nrst_in(por_nrst_in), .wake_in(wake_in), .comparator_in(comparator_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
	.rdata_out(rdata_out), .threshold_out(threshold_out),
	.monitor_enable_out(monitor_enable_out), .brownout_reset_out(brownout_reset_out),
	.sysctrl_irq_out(sysctrl_irq_out));
always @(posedge clock_in) if (brownout_reset_out === 1'h1) pulses++;
function automatic logic [31:0] lfsr(input logic [31:0] s);
	return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
function automatic logic [31:0] cfg(input logic [2:0] t, input logic r, m, x, e);
	return {25'h0, e, x, m, r, t};
endfunction
task automatic final_report();
	$display("errors=%0d checks=%0d", errors, checks);
	if (errors == 0 && checks > 0)
		$display("ALL TESTS PASSED");
	else
		$display("TESTS FAILED");
	$finish;
endtask
task automatic chk(input logic [31:0] g, input logic [31:0] e);
	checks++;
	if (g !== e) begin
		errors++;
		$display("MISMATCH %0t got %h expected %h", $time, g, e);
	end
endtask
task automatic cyc(input int n);
	repeat (n) @(posedge clock_in);
endtask
task automatic wr(input logic [3:0] a, input logic [31:0] v);
	@(posedge clock_in);
	write_in <= 1'h1;
	addr_in <= a;
	wdata_in <= v;
	@(posedge clock_in);
	write_in <= 1'h0;
	#1;
endtask
task automatic rd(input logic [3:0] a);
	@(posedge clock_in);
	read_in <= 1'h1;
	addr_in <= a;
	@(posedge clock_in);
	read_in <= 1'h0;
	#1 d = rdata_out;
endtask
// Waiting out the settle time keeps comparator edges from being ignored.
task automatic cfgw(input logic [31:0] v);
	wr(CONFIG_OFFSET, v);
	cyc(SETTLE_CYCLES + 4);
endtask
task automatic cmp(input logic v);
	@(posedge clock_in);
	comparator_in <= v;
	cyc(8);
	#1;
endtask
initial begin
	cyc(4);
	nrst_in <= 1'h1;
	por_nrst_in <= 1'h1;
	#1 chk(32'(threshold_out), 32'h1);
	chk(32'(monitor_enable_out), 32'h1);
	rd(CONFIG_OFFSET);
	chk(d & 32'h1f, 32'h19);
	rd(CAUSE_OFFSET);
	chk(d, 32'h0);
	rd(4'h1);
	chk(d, 32'h0);
	for (int t = 0; t < 8; t++) begin
		rnd = lfsr(rnd);
		wr(CONFIG_OFFSET, cfg(3'(t), 1'h0, 1'h1, rnd[0], rnd[1]));
		chk(32'(threshold_out), 32'(t));
		rd(CONFIG_OFFSET);
		chk(d & 32'h7f, cfg(3'(t), 1'h0, 1'h1, rnd[0], rnd[1]));
	end
	cfgw(cfg(rnd[4:2], 1'h0, 1'h1, 1'h0, 1'h0));
	cmp(1'h1);
	rd(STATUS_OFFSET);
	chk(d, 32'h1);
	cmp(1'h0);
	rd(STATUS_OFFSET);
	chk(d, 32'h0);
	rd(EVENT_OFFSET);
	chk(d, BROWNOUT_ENTRY_EVENT_MASK | BROWNOUT_EXIT_EVENT_MASK);
	rd(EVENT_OFFSET);
	chk(d, 32'h0);
	chk(32'(pulses), 32'h0);
	cfgw(cfg(rnd[7:5], 1'h0, 1'h1, 1'h0, 1'h1));
	cmp(1'h1);
	chk(32'(sysctrl_irq_out), 32'h1);
	wr(EVENT_OFFSET, 32'h0);
	chk(32'(sysctrl_irq_out), 32'h1);
	wr(EVENT_OFFSET, BROWNOUT_ENTRY_EVENT_MASK);
	chk(32'(sysctrl_irq_out), 32'h0);
	cfgw(cfg(rnd[10:8], 1'h0, 1'h1, 1'h1, 1'h0));
	cmp(1'h0);
	chk(32'(sysctrl_irq_out), 32'h1);
	rd(EVENT_OFFSET);
	chk(d, BROWNOUT_EXIT_EVENT_MASK);
	chk(32'(sysctrl_irq_out), 32'h0);
	cfgw(cfg(3'h1, 1'h0, 1'h0, 1'h1, 1'h1));
	cmp(1'h1);
	rd(STATUS_OFFSET);
	chk(d, 32'h0);
	rd(EVENT_OFFSET);
	chk(d, 32'h0);
	cmp(1'h0);
	wr(CONFIG_OFFSET, cfg(3'h5, 1'h0, 1'h1, 1'h0, 1'h0));
	@(posedge clock_in);
	wake_in <= 1'h1;
	@(posedge clock_in);
	wake_in <= 1'h0;
	#1 chk(32'(threshold_out), 32'h1);
	rd(CONFIG_OFFSET);
	chk(d & 32'h1f, 32'h19);
	cyc(SETTLE_CYCLES + 4);
	@(posedge clock_in);
	comparator_in <= 1'h1;
	// The bench plays the system reset that the request would cause.
	for (int i = 0; i <= 40; i++) begin
		@(posedge clock_in);
		#1 if (brownout_reset_out === 1'h1) break;
		if (i == 40) begin
			chk(32'h0, 32'h1);
			final_report();
		end
	end
	@(posedge clock_in);
	nrst_in <= 1'h0;
	cyc(2);
	nrst_in <= 1'h1;
	comparator_in <= 1'h0;
	rd(CAUSE_OFFSET);
	chk(d, 32'h1);
	chk(32'(pulses), 32'h1);
	@(posedge clock_in);
	nrst_in <= 1'h0;
	cyc(2);
	nrst_in <= 1'h1;
	rd(CAUSE_OFFSET);
	chk(d, 32'h0);
	final_report();
end
endmodule // tb_brownout_supervisor_control
`default_nettype wire
